// ===== tmr8_counter.sv
// 8-bit timer/counter with one compare channel, wishbone slave
`timescale 1ns/10ps
`default_nettype none
// Function
// [R1] clock select zero gives no ticks; the counter holds
// [R2] count value readable/writable anytime; bus write beats clear or count
// [R3] each tick clears, increments or decrements per mode and direction
// [R4] count equal compare sets match flag on following tick
// [R5] compare irq only when enable and global enable set
// [R6] match flag cleared on service or by writing one
// [R7] pwm modes buffer compare writes, update at top or bottom
// [R8] bus compare access hits buffer when buffering, else active register
// [R9] force strobe applies action in non-pwm modes, no flag, no reload
// [R10] count write blocks compare match on next tick, even stopped
// [R11] action field unbuffered, takes effect at next match or force
// [R12] reset clears output waveform register; mode changes keep it
// [R13] nonzero action overrides port output; direction from port bit
// [R14] action zero leaves output waveform register unchanged
// [R15] count sequence from mode only; action selects polarity or action
// [R16] normal mode counts up, wraps ff to 00
// [R17] normal mode overflow flag set as count becomes zero; sticky
// [R18] normal mode accepts count writes anytime
// [R19] software avoids writing count equal compare, or bottom downcounting
// [R20] software initialises output via force before enabling the pin
// [R21] mode 0 normal, 1 phase pwm, 2 ctc, 3 fast pwm
// [R22] tick is one-cycle enable; flags registered on same clock
module tmr8_counter
  import tmr8_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        timer_src_tick,
  input  wire logic        global_irq_enable,
  input  wire logic        irq_serviced_cmp,
  input  wire logic        irq_serviced_ovf,
  input  wire logic        port_data_bit,
  input  wire logic        output_pin_direction_bit,
  output logic             pin_o,
  output logic             pin_oe_n,
  output tmr8_irq_t        irq_o
);

  tmr8_ctrl_t       ctrl_reg;
  logic [CNT_W-1:0] count_value_reg;
  logic [CNT_W-1:0] compare_value_reg;
  logic [CNT_W-1:0] compare_buf_reg;
  logic             compare_match_flag_reg;
  logic             overflow_flag_reg;
  logic             compare_irq_enable_reg;
  logic             overflow_irq_enable_reg;
  logic             output_waveform_register;
  logic             down_reg;
  logic             block_reg;
  logic [CNT_W-1:0] count_value_next;
  logic             down_next;
  logic             timer_tick;
  logic             wr;
  logic             rd;
  logic             cnt_wr;
  logic             cmp_wr;
  logic             flg_wr;
  logic             force_strobe;
  logic             is_pwm;
  logic             match;
  logic             top_hit;
  logic             ovf_event;
  logic             apply_match;
  logic             buf_update;

  function automatic logic pwm_mode(input tmr8_wgm_t m);
    pwm_mode = (m == TMR8_WGM_PCPWM) || (m == TMR8_WGM_FPWM);
  endfunction

  function automatic logic wave_action(input logic cur, input logic [1:0] com,
                                       input logic pwm, input logic up);
    // [R15]
    if (com == COM_NONE) begin // [R14]
      wave_action = cur;
    end else if (!pwm) begin
      case (com)
        2'd1:    wave_action = ~cur;
        2'd2:    wave_action = 1'b0;
        default: wave_action = 1'b1;
      endcase
    end else begin
      // pwm: com 3 inverted, sets on upcount match; other com non-inverted, clears on upcount match
      wave_action = (com == 2'd3) ? up : ~up;
    end
  endfunction

  // bus decode
  assign wr           = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  assign rd           = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  assign cnt_wr       = wr && (wb_adr_i == ADDR_COUNT);
  assign cmp_wr       = wr && (wb_adr_i == ADDR_CMP);
  assign flg_wr       = wr && (wb_adr_i == ADDR_FLAGS);
  assign is_pwm       = pwm_mode(ctrl_reg.waveform_mode_field);
  assign force_strobe = wr && (wb_adr_i == ADDR_CTRL) && wb_dat_i[CTRL_FOC_BIT] && !is_pwm;
  assign timer_tick   = timer_src_tick && (ctrl_reg.clock_select_field != CS_STOP); // [R1] [R22]
  assign match        = (count_value_reg == compare_value_reg); // [R4]

  // next count per mode
  always_comb begin
    count_value_next = count_value_reg + 8'h01;
    down_next        = 1'b0;
    top_hit          = 1'b0;
    ovf_event        = 1'b0;
    case (ctrl_reg.waveform_mode_field) // [R3] [R21]
      TMR8_WGM_NORMAL: begin
        ovf_event = (count_value_reg == CNT_MAX); // [R16] [R17]
      end
      TMR8_WGM_CTC: begin
        if (match) begin
          count_value_next = CNT_BOTTOM;
        end
        ovf_event = (count_value_reg == CNT_MAX);
      end
      TMR8_WGM_FPWM: begin
        ovf_event = (count_value_reg == CNT_MAX);
        top_hit   = ovf_event;
      end
      TMR8_WGM_PCPWM: begin
        down_next = down_reg;
        if (!down_reg && count_value_reg == CNT_MAX) begin
          down_next        = 1'b1;
          count_value_next = count_value_reg - 8'h01;
          top_hit          = 1'b1;
        end else if (down_reg && count_value_reg == CNT_BOTTOM) begin
          down_next        = 1'b0;
          count_value_next = count_value_reg + 8'h01;
        end else if (down_reg) begin
          count_value_next = count_value_reg - 8'h01;
          ovf_event        = (count_value_reg == 8'h01);
        end
      end
      default: begin
        count_value_next = count_value_reg;
      end
    endcase
  end

  // match present at a tick sets the flag at that tick unless a count write blocks it
  assign apply_match = timer_tick && match && !block_reg && !cnt_wr; // [R4] [R10]
  assign buf_update  = timer_tick && top_hit;

  // control register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_reg <= '0;
    end else if (wr && wb_adr_i == ADDR_CTRL) begin
      ctrl_reg.clock_select_field  <= wb_dat_i[CTRL_CS_LSB +: 3];
      ctrl_reg.waveform_mode_field <= tmr8_wgm_t'(wb_dat_i[CTRL_WGM_LSB +: 2]);
      ctrl_reg.output_action_field <= wb_dat_i[CTRL_COM_LSB +: 2]; // [R11]
    end
  end

  // counter
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_value_reg <= CNT_BOTTOM;
      down_reg        <= 1'b0;
    end else if (cnt_wr) begin
      count_value_reg <= wb_dat_i[CNT_W-1:0]; // [R2] [R18]
    end else if (timer_tick) begin
      count_value_reg <= count_value_next; // [R3]
      down_reg        <= down_next;
    end
  end

  // count writes block the match of the next tick
  always_ff @(posedge core_clk) begin
    if (srst) begin
      block_reg <= 1'b0;
    end else if (cnt_wr) begin
      block_reg <= 1'b1; // [R10]
    end else if (timer_tick) begin
      block_reg <= 1'b0;
    end
  end

  // compare and buffer registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      compare_value_reg <= CNT_BOTTOM;
      compare_buf_reg   <= CNT_BOTTOM;
    end else begin
      if (cmp_wr) begin
        compare_buf_reg <= wb_dat_i[CNT_W-1:0]; // [R8]
      end
      if (cmp_wr && !is_pwm) begin
        compare_value_reg <= wb_dat_i[CNT_W-1:0]; // [R7] [R8]
      end else if (is_pwm && buf_update) begin
        compare_value_reg <= compare_buf_reg; // [R7]
      end
    end
  end

  // flags, set wins over clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      compare_match_flag_reg <= 1'b0;
      overflow_flag_reg      <= 1'b0;
    end else begin
      if (apply_match) begin
        compare_match_flag_reg <= 1'b1; // [R4] [R22]
      end else if (irq_serviced_cmp || (flg_wr && wb_dat_i[FLG_CMP_BIT])) begin
        compare_match_flag_reg <= 1'b0; // [R6]
      end
      if (timer_tick && ovf_event && !cnt_wr) begin
        overflow_flag_reg <= 1'b1; // [R17]
      end else if (irq_serviced_ovf || (flg_wr && wb_dat_i[FLG_OVF_BIT])) begin
        overflow_flag_reg <= 1'b0; // [R17]
      end
    end
  end

  // irq enables
  always_ff @(posedge core_clk) begin
    if (srst) begin
      compare_irq_enable_reg  <= 1'b0;
      overflow_irq_enable_reg <= 1'b0;
    end else if (wr && wb_adr_i == ADDR_IRQCTL) begin
      compare_irq_enable_reg  <= wb_dat_i[IRQ_CMPEN_BIT];
      overflow_irq_enable_reg <= wb_dat_i[IRQ_OVFEN_BIT];
    end
  end

  // output waveform register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      output_waveform_register <= 1'b0; // [R12]
    end else if (force_strobe) begin
      output_waveform_register <= wave_action(output_waveform_register,
                                  wb_dat_i[CTRL_COM_LSB +: 2], 1'b0, 1'b1); // [R9] [R11]
    end else if (apply_match) begin
      output_waveform_register <= wave_action(output_waveform_register,
                                  ctrl_reg.output_action_field, is_pwm, !down_reg); // [R11]
    end else if (timer_tick && ctrl_reg.waveform_mode_field == TMR8_WGM_FPWM
                 && count_value_reg == CNT_MAX && ctrl_reg.output_action_field[1]) begin
      output_waveform_register <= !ctrl_reg.output_action_field[0];
    end
  end

  // pin override and irq outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_o    <= 1'b0;
      pin_oe_n <= 1'b1;
      irq_o    <= '0;
    end else begin
      pin_o    <= (ctrl_reg.output_action_field != COM_NONE) ?
                  output_waveform_register : port_data_bit; // [R13]
      pin_oe_n <= !output_pin_direction_bit; // [R13] [R20]
      irq_o.compare_irq  <= compare_match_flag_reg && compare_irq_enable_reg
                            && global_irq_enable; // [R5]
      irq_o.overflow_irq <= overflow_flag_reg && overflow_irq_enable_reg
                            && global_irq_enable;
    end
  end

  // wishbone answer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= BUS_ZERO;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= BUS_ZERO;
      if (rd) begin
        case (wb_adr_i)
          ADDR_CTRL:   wb_dat_o[7:0] <= {1'b0, ctrl_reg.output_action_field,
                                         ctrl_reg.waveform_mode_field,
                                         ctrl_reg.clock_select_field};
          ADDR_COUNT:  wb_dat_o[7:0] <= count_value_reg; // [R2]
          ADDR_CMP:    wb_dat_o[7:0] <= is_pwm ? compare_buf_reg : compare_value_reg; // [R8]
          ADDR_FLAGS:  wb_dat_o[1:0] <= {overflow_flag_reg, compare_match_flag_reg};
          ADDR_IRQCTL: wb_dat_o[1:0] <= {overflow_irq_enable_reg, compare_irq_enable_reg};
          ADDR_STATUS: wb_dat_o[1:0] <= {down_reg, output_waveform_register};
          default:     wb_dat_o <= BUS_ZERO;
        endcase
      end
    end
  end

endmodule // tmr8_counter
`default_nettype wire

// ===== tmr8_counter_chk.sv
// assertion checker for the timer compare unit
`timescale 1ns/10ps
`default_nettype none
module tmr8_counter_chk
  import tmr8_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        global_irq_enable,
  input wire logic        port_data_bit,
  input wire logic        output_pin_direction_bit,
  input wire logic        pin_o,
  input wire logic        pin_oe_n,
  input wire tmr8_irq_t   irq_o
);
  logic [1:0] act_reg;
  logic [1:0] ien_reg;
  logic       wr_take;
  assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  // shadow of action field
  always_ff @(posedge core_clk) begin
    if (srst) begin
      act_reg <= COM_NONE;
    end else if (wr_take && wb_adr_i == ADDR_CTRL) begin
      act_reg <= wb_dat_i[6:5];
    end
  end
  // shadow of irq enables
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ien_reg <= 2'h0;
    end else if (wr_take && wb_adr_i == ADDR_IRQCTL) begin
      ien_reg <= wb_dat_i[1:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  AST_ACK_REQ: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked in one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == BUS_ZERO)
    else $error("read data outside ack");
  AST_OE_DIR: assert property (!srst |=> pin_oe_n == !$past(output_pin_direction_bit))
    else $error("pin enable not from direction bit");
  AST_PIN_PORT: assert property (!srst && act_reg == COM_NONE |=> pin_o == $past(port_data_bit))
    else $error("pin not from port with action zero");
  AST_IRQ_CMP: assert property (irq_o.compare_irq |-> $past(global_irq_enable && ien_reg[0]))
    else $error("compare irq without enables");
  AST_IRQ_OVF: assert property (irq_o.overflow_irq |-> $past(global_irq_enable && ien_reg[1]))
    else $error("overflow irq without enables");
  AST_RST_OUT: assert property ($fell(srst) |-> !wb_ack_o && !pin_o && pin_oe_n)
    else $error("outputs not reset");
endmodule // tmr8_counter_chk
bind tmr8_counter tmr8_counter_chk u_chk (
  .core_clk(core_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .global_irq_enable(global_irq_enable),
  .port_data_bit(port_data_bit), .output_pin_direction_bit(output_pin_direction_bit),
  .pin_o(pin_o), .pin_oe_n(pin_oe_n), .irq_o(irq_o));
`default_nettype wire

// ===== tmr8_pkg.sv
// package for the 8-bit timer/counter compare unit
package tmr8_pkg;

  localparam int unsigned CNT_W = 8;

  // register word offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_COUNT  = 8'h04;
  localparam logic [7:0] ADDR_CMP    = 8'h08;
  localparam logic [7:0] ADDR_FLAGS  = 8'h0C;
  localparam logic [7:0] ADDR_IRQCTL = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // control register fields
  localparam int unsigned CTRL_CS_LSB    = 0;
  localparam int unsigned CTRL_WGM_LSB   = 3;
  localparam int unsigned CTRL_COM_LSB   = 5;
  localparam int unsigned CTRL_FOC_BIT   = 7;
  // flag register fields
  localparam int unsigned FLG_CMP_BIT    = 0;
  localparam int unsigned FLG_OVF_BIT    = 1;
  // irq control fields
  localparam int unsigned IRQ_CMPEN_BIT  = 0;
  localparam int unsigned IRQ_OVFEN_BIT  = 1;
  localparam int unsigned IRQ_ACKCMP_BIT = 2;
  localparam int unsigned IRQ_ACKOVF_BIT = 3;
  // status register fields
  localparam int unsigned ST_OUT_BIT     = 0;
  localparam int unsigned ST_DIR_BIT     = 1;

  localparam logic [7:0]  CNT_MAX        = 8'hFF;
  localparam logic [7:0]  CNT_BOTTOM     = 8'h00;
  localparam logic [2:0]  CS_STOP        = 3'h0;
  localparam logic [1:0]  COM_NONE       = 2'h0;
  localparam logic [31:0] BUS_ZERO       = 32'h0000_0000;

  typedef enum logic [1:0] {
    TMR8_WGM_NORMAL = 2'd0,
    TMR8_WGM_PCPWM  = 2'd1,
    TMR8_WGM_CTC    = 2'd2,
    TMR8_WGM_FPWM   = 2'd3
  } tmr8_wgm_t;

  typedef struct packed {
    logic [2:0] clock_select_field;
    tmr8_wgm_t  waveform_mode_field;
    logic [1:0] output_action_field;
  } tmr8_ctrl_t;

  typedef struct packed {
    logic compare_irq;
    logic overflow_irq;
  } tmr8_irq_t;

endpackage : tmr8_pkg

// ===== tmr8_tb.sv
// self-checking testbench for the timer compare unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tmr8_pkg::*;
  logic        core_clk, srst, cyc, stb, we, tick, gie, svc_c, svc_o, pdat, dir;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic        ack, pin, pin_oe_n;
  tmr8_irq_t   irq;
  int          errors, compares;
  tmr8_counter u_dut (.core_clk(core_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .timer_src_tick(tick), .global_irq_enable(gie),
    .irq_serviced_cmp(svc_c), .irq_serviced_ovf(svc_o), .port_data_bit(pdat),
    .output_pin_direction_bit(dir), .pin_o(pin), .pin_oe_n(pin_oe_n), .irq_o(irq));
  always #2.5 core_clk = ~core_clk;
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge core_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic tk(input int n);
    repeat (n) begin
      tick <= 1'b1; @(posedge core_clk);
      tick <= 1'b0; @(posedge core_clk);
    end
  endtask
  function automatic logic [31:0] c(logic [2:0] cs, logic [1:0] m, logic [1:0] ac, logic f);
    return {24'h00_0000, f, ac, m, cs};
  endfunction
  task automatic t_reset;
    for (int a = 0; a <= 24; a += 4) rd(a[7:0], 32'h0000_0000);
    wr(8'h18, 32'h0000_00FF);
    rd(8'h18, 32'h0000_0000);
  endtask
  task automatic t_stop;
    wr(ADDR_CTRL, c(CS_STOP, 2'h0, 2'h0, 1'b0));
    wr(ADDR_COUNT, 32'h0000_0005);
    tk(3);
    rd(ADDR_COUNT, 32'h0000_0005);
  endtask
  task automatic t_normal;
    wr(ADDR_CTRL, c(3'h1, 2'h0, 2'h0, 1'b0));
    wr(ADDR_COUNT, 32'h0000_00FE);
    tk(1);
    rd(ADDR_FLAGS, 32'h0000_0000);
    tk(1);
    rd(ADDR_COUNT, 32'h0000_0000);
    rd(ADDR_FLAGS, 32'h0000_0002);
    tk(1);
    rd(ADDR_FLAGS, 32'h0000_0003);
    wr(ADDR_FLAGS, 32'h0000_0003);
    rd(ADDR_FLAGS, 32'h0000_0000);
  endtask
  task automatic t_match;
    wr(ADDR_CMP, 32'h0000_0010);
    wr(ADDR_COUNT, 32'h0000_000F);
    tk(2);
    rd(ADDR_FLAGS, 32'h0000_0001);
    wr(ADDR_IRQCTL, 32'h0000_0001);
    gie <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(irq, 2'b10);
    gie <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(irq.compare_irq, 1'b0);
    svc_c <= 1'b1; @(posedge core_clk);
    svc_c <= 1'b0; @(posedge core_clk);
    rd(ADDR_FLAGS, 32'h0000_0000);
    wr(ADDR_CMP, 32'h0000_0020);
    wr(ADDR_COUNT, 32'h0000_0020);
    tk(2);
    rd(ADDR_FLAGS, 32'h0000_0000);
  endtask
  task automatic t_force;
    logic [3:0] ex;
    ex = 4'b1101;
    wr(ADDR_CTRL, c(CS_STOP, 2'h0, 2'h0, 1'b0));
    wr(ADDR_COUNT, 32'h0000_0033);
    pdat <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      dir <= (i > 0);
      wr(ADDR_CTRL, c(CS_STOP, 2'h0, 2'((i + 1) % 4), 1'b1));
      rd(ADDR_STATUS, {31'h0, ex[i]});
      if (i == 2) chk({pin, pin_oe_n}, 2'b10);
    end
    chk(pin, 1'b0);
    rd(ADDR_FLAGS, 32'h0000_0000);
    rd(ADDR_COUNT, 32'h0000_0033);
  endtask
  task automatic t_buffer;
    wr(ADDR_CTRL, c(3'h1, 2'h2, 2'h0, 1'b0));
    wr(ADDR_CMP, 32'h0000_0030);
    wr(ADDR_CTRL, c(3'h1, 2'h3, 2'h0, 1'b0));
    wr(ADDR_CMP, 32'h0000_0050);
    rd(ADDR_CMP, 32'h0000_0050);
    wr(ADDR_COUNT, 32'h0000_002E);
    tk(3);
    rd(ADDR_FLAGS, 32'h0000_0001);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CTRL, c(CS_STOP, 2'(m), 2'h0, 1'b0));
      rd(ADDR_CTRL, c(CS_STOP, 2'(m), 2'h0, 1'b0));
    end
    bus(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(q[0], 1'b1);
  endtask
  initial begin
    core_clk = 1'b0; srst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; tick = 1'b0;
    gie = 1'b0; svc_c = 1'b0; svc_o = 1'b0; pdat = 1'b1; dir = 1'b0;
    adr = 8'h00; wdat = 32'h0000_0000; errors = 0; compares = 0;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_stop();
    t_normal();
    t_match();
    t_force();
    t_buffer();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
